// ==== hw/ioce_pkg.sv ====
// Purpose: shared constants and types for the chain enumeration controller
// Assumes: configuration accesses are 32-bit word reads and writes
// Notes: register word indices are local choices of this controller
package ioce_pkg;
  localparam logic [4:0] IOCE_FIRST_UNIT = 5'h01;
  localparam logic [4:0] IOCE_MAX_UNIT_DEF = 5'h1f;
  localparam logic [31:0] IOCE_MASK_RESET = 32'h0000_0000;
  localparam logic [4:0] IOCE_DEFAULT_DEV = 5'h00;
  // word indices inside a node's configuration space
  localparam logic [7:0] IOCE_REG_ID = 8'h00;
  localparam logic [7:0] IOCE_REG_CMD = 8'h01;
  localparam logic [7:0] IOCE_REG_LINK = 8'h02;
  localparam logic [7:0] IOCE_REG_FEATURE = 8'h03;
  localparam logic [7:0] IOCE_REG_GRP_SUP = 8'h04;
  localparam logic [7:0] IOCE_REG_GRP_EN = 8'h05;
  // command register fields
  localparam int IOCE_CMD_BASE_LSB = 0;
  localparam int IOCE_CMD_UNITQ_LSB = 5;
  localparam int IOCE_CMD_HOSTDIR_BIT = 10;
  localparam int IOCE_CMD_SLAVEHOST_BIT = 11;
  localparam int IOCE_CMD_GRPCAP_BIT = 12;
  localparam int IOCE_CMD_TWOHOST_BIT = 13;
  // link control/status fields
  localparam int IOCE_LNK_INITDONE_BIT = 0;
  localparam int IOCE_LNK_CRC_BIT = 1;
  localparam int IOCE_LNK_PROTO_BIT = 2;
  localparam int IOCE_LNK_OVF_BIT = 3;
  localparam int IOCE_LNK_EOCERR_BIT = 4;
  localparam int IOCE_LNK_CHAINEND_BIT = 5;
  localparam int IOCE_LNK_TRANSMITTER_OFF_BIT_BIT = 6;
  localparam int IOCE_LNK_FLOOD_BIT = 7;
  localparam int IOCE_LNK_FATAL_BIT = 8;
  localparam int IOCE_LNK_NONFATAL_BIT = 9;
  localparam int IOCE_FEAT_REORDIS_BIT = 0;
  localparam int IOCE_TIMEOUT_NS = 4000;
  localparam int IOCE_CLK_NS = 4;
  localparam int IOCE_TIMEOUT_CYC = IOCE_TIMEOUT_NS / IOCE_CLK_NS;

  typedef struct packed {
    logic        wr;
    logic [4:0]  dev;
    logic [7:0]  idx;
    logic [31:0] wdata;
  } ioce_req_t;

  typedef struct packed {
    logic [4:0]  units;
    logic [31:0] group_mask;
    logic        partial_grp;
    logic        grp_forbidden;
    logic        two_host;
    logic        error_end;
  } ioce_result_t;
endpackage

// ==== hw/ioce_timer.sv ====
// Purpose: access watchdog for sizing configuration accesses
// Assumes: start is a one-cycle pulse when an access is issued
// Notes: expired pulses once after LIMIT cycles with no clear
`timescale 1ns/10ps
`default_nettype none
module ioce_timer
  import ioce_pkg::*;
#(
  parameter int LIMIT = IOCE_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic clear,
  output logic expired
);
  logic [15:0] cnt_q, cnt_d;
  logic run_q, run_d;
  logic exp_q, exp_d;

  initial
  begin
    if (LIMIT < 1 || LIMIT > 65535)
    begin
      $error("ioce_timer LIMIT out of range");
    end
  end

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (start)
    begin
      cnt_d = 16'h0000;
      run_d = 1'b1;
    end
    else if (clear)
    begin
      run_d = 1'b0;
    end
    else if (run_q)
    begin
      if (cnt_q == 16'(LIMIT - 1))
      begin
        exp_d = 1'b1;
        run_d = 1'b0;
      end
      else
      begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= 16'h0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule
`default_nettype wire

// ==== hw/ioce_enum.sv ====
// Purpose: master host chain enumeration sequencer
// Assumes: one outstanding configuration access; cfg_ack answers it
// Notes: own link status is read at device index own_dev
`timescale 1ns/10ps
`default_nettype none
module ioce_enum
  import ioce_pkg::*;
#(
  parameter logic [4:0] MAX_UNIT = IOCE_MAX_UNIT_DEF,
  parameter int TIMEOUT_CYC = IOCE_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chain_reset_n,
  input wire logic start,
  input wire logic is_slave,
  input wire logic want_group,
  input wire logic passive_group,
  input wire logic [4:0] own_dev,
  input wire logic [3:0] host_group_bits,
  output logic cfg_req_valid,
  output ioce_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  output logic busy,
  output logic done,
  output logic bus_master_ok,
  output ioce_result_t result
);
  typedef enum logic [4:0] {
    S_IDLE    = 5'h00, S_WAKE  = 5'h01, S_LINK   = 5'h02, S_ID    = 5'h03,
    S_CMDWR   = 5'h04, S_CMDRD = 5'h05, S_NLINK  = 5'h06, S_ERREN = 5'h07,
    S_REORD   = 5'h08, S_REOCHK= 5'h09, S_GRPRD  = 5'h0a, S_BASE  = 5'h0b,
    S_TWO_N   = 5'h0c, S_TWO_H = 5'h0d, S_END    = 5'h0e, S_GRPEN = 5'h0f,
    S_DONE    = 5'h10, S_HOP   = 5'h11
  } ioce_state_t;

  ioce_state_t st_q, st_d;
  logic [4:0] next_unit_q, next_unit_d;
  logic [4:0] last_dev_q, last_dev_d;
  logic [4:0] quant_q, quant_d;
  logic [4:0] grp_walk_q, grp_walk_d;
  logic [31:0] merged_q, merged_d;
  logic [31:0] cap_map_q, cap_map_d;
  logic partial_q, partial_d, forbid_q, forbid_d;
  logic two_host_q, two_host_d, err_end_q, err_end_d;
  logic pend_q, pend_d, to_q, to_d;
  logic [31:0] rdat_q, rdat_d;
  logic req_v_q, req_v_d, done_q, done_d;
  ioce_req_t req_q, req_d;
  logic timed_out;
  logic [31:0] shifted;
  logic [5:0] sum;

  initial
  begin
    if (MAX_UNIT < 5'h02)
    begin
      $error("ioce_enum MAX_UNIT too small");
    end
  end

  ioce_timer #(.LIMIT(TIMEOUT_CYC)) u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .start(req_v_q),
    .clear(cfg_ack),
    .expired(timed_out)
  );

  // grouping bits 1..quantity-1 moved to start at next unit plus one
  always_comb
  begin
    shifted = 32'h0000_0000;
    for (int i = 1; i < 32; i++)
    begin
      if (i < int'(quant_q) && (int'(next_unit_q) + i) < 32)
      begin
        shifted[int'(next_unit_q) + i] = rdat_q[i];
      end
    end
  end

  assign sum = {1'b0, next_unit_q} + {1'b0, quant_q};

  always_comb
  begin
    st_d = st_q;
    next_unit_d = next_unit_q;
    last_dev_d = last_dev_q;
    quant_d = quant_q;
    grp_walk_d = grp_walk_q;
    merged_d = merged_q;
    cap_map_d = cap_map_q;
    partial_d = partial_q;
    forbid_d = forbid_q;
    two_host_d = two_host_q;
    err_end_d = err_end_q;
    pend_d = pend_q;
    req_v_d = 1'b0;
    req_d = req_q;
    done_d = done_q;
    rdat_d = rdat_q;
    to_d = to_q;
    // answer word kept, the read bus does not hold it past the ack
    if (cfg_ack)
    begin
      rdat_d = cfg_rdata;
      to_d = 1'b0;
    end
    else if (timed_out)
    begin
      rdat_d = 32'h0000_0000;
      to_d = 1'b1;
    end
    // only one access in flight; ack or timeout retires it
    if (req_v_q)
    begin
      pend_d = 1'b1;
    end
    if (cfg_ack || timed_out)
    begin
      pend_d = 1'b0;
    end
    unique case (st_q)
      S_IDLE:
      begin
        // shared reset must be fully released before sizing
        if (start && chain_reset_n)
        begin
          done_d = 1'b0;
          next_unit_d = IOCE_FIRST_UNIT + {3'b000, host_group_bits[3] ? 2'd3 :
            host_group_bits[2] ? 2'd2 : host_group_bits[1] ? 2'd1 : 2'd0};
          merged_d = IOCE_MASK_RESET;
          cap_map_d = 32'h0000_0000;
          partial_d = 1'b0;
          forbid_d = 1'b0;
          two_host_d = 1'b0;
          err_end_d = 1'b0;
          last_dev_d = own_dev;
          req_v_d = 1'b1;
          req_d = '{wr: 1'b0, dev: own_dev, idx: is_slave ? IOCE_REG_CMD : IOCE_REG_LINK, wdata: 32'h0};
          st_d = is_slave ? S_WAKE : S_LINK;
        end
      end
      S_WAKE:
      begin
        if (!pend_q && !req_v_q)
        begin
          // slave sizes when its two-host bit is clear or the command read timed out
          if (!to_q && rdat_q[IOCE_CMD_TWOHOST_BIT])
          begin
            two_host_d = 1'b1;
            st_d = S_DONE;
          end
          else
          begin
            req_v_d = 1'b1;
            req_d = '{wr: 1'b0, dev: own_dev, idx: IOCE_REG_LINK, wdata: 32'h0};
            st_d = S_LINK;
          end
        end
      end
      S_LINK:
      begin
        if (!pend_q && !req_v_q)
        begin
          if (to_q || !rdat_q[IOCE_LNK_INITDONE_BIT] || (|rdat_q[4:1]))
          begin
            err_end_d = |rdat_q[4:1];
            st_d = S_END;
          end
          else
          begin
            req_v_d = 1'b1;
            req_d = '{wr: 1'b0, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_CMD, wdata: 32'h0};
            st_d = S_ID;
          end
        end
      end
      S_ID:
      begin
        if (!pend_q && !req_v_q)
        begin
          if (to_q)
          begin
            st_d = S_END;
          end
          else
          begin
            quant_d = rdat_q[IOCE_CMD_UNITQ_LSB +: 5];
            // rewrite unchanged to latch the host direction
            req_v_d = 1'b1;
            req_d = '{wr: 1'b1, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_CMD, wdata: rdat_q};
            st_d = rdat_q[IOCE_CMD_SLAVEHOST_BIT] ? S_TWO_N : S_CMDWR;
          end
        end
      end
      S_CMDWR:
      begin
        if (!pend_q && !req_v_q)
        begin
          req_v_d = !to_q;
          req_d = '{wr: 1'b0, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_LINK, wdata: 32'h0};
          st_d = to_q ? S_END : S_NLINK;
        end
      end
      S_NLINK:
      begin
        if (!pend_q && !req_v_q)
        begin
          if (to_q || (|rdat_q[4:1]))
          begin
            err_end_d = ~to_q;
            st_d = S_END;
          end
          else if (sum > {1'b0, MAX_UNIT} + 6'd1)
          begin
            st_d = S_END;
          end
          else
          begin
            req_v_d = 1'b1;
            req_d = '{wr: 1'b1, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_LINK,
              wdata: rdat_q | 32'h0000_0380};
            st_d = S_ERREN;
          end
        end
      end
      S_ERREN:
      begin
        if (!pend_q && !req_v_q)
        begin
          req_v_d = 1'b1;
          req_d = '{wr: 1'b0, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_CMD, wdata: 32'h0};
          st_d = S_CMDRD;
        end
      end
      S_CMDRD:
      begin
        if (!pend_q && !req_v_q)
        begin
          if (!want_group)
          begin
            st_d = S_BASE;
          end
          else if (rdat_q[IOCE_CMD_GRPCAP_BIT])
          begin
            cap_map_d[next_unit_q] = 1'b1;
            req_v_d = 1'b1;
            req_d = '{wr: 1'b0, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_GRP_SUP, wdata: 32'h0};
            st_d = S_GRPRD;
          end
          else
          begin
            partial_d = 1'b1;
            req_v_d = 1'b1;
            req_d = '{wr: 1'b1, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_FEATURE,
              wdata: 32'h0000_0001 << IOCE_FEAT_REORDIS_BIT};
            st_d = S_REORD;
          end
        end
      end
      S_REORD:
      begin
        if (!pend_q && !req_v_q)
        begin
          req_v_d = 1'b1;
          req_d = '{wr: 1'b0, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_FEATURE, wdata: 32'h0};
          st_d = S_REOCHK;
        end
      end
      S_REOCHK:
      begin
        if (!pend_q && !req_v_q)
        begin
          if (to_q || !rdat_q[IOCE_FEAT_REORDIS_BIT])
          begin
            forbid_d = 1'b1;
          end
          st_d = S_BASE;
        end
      end
      S_GRPRD:
      begin
        if (!pend_q && !req_v_q)
        begin
          if (!forbid_q && !to_q)
          begin
            merged_d = merged_q | shifted;
          end
          st_d = S_BASE;
        end
      end
      S_BASE:
      begin
        req_v_d = 1'b1;
        req_d = '{wr: 1'b1, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_CMD,
          wdata: {27'h0, next_unit_q}};
        last_dev_d = next_unit_q;
        next_unit_d = sum[4:0];
        st_d = S_HOP;
      end
      S_HOP:
      begin
        // next hop begins with the newly named node's outgoing link
        if (!pend_q && !req_v_q)
        begin
          req_v_d = !to_q;
          req_d = '{wr: 1'b0, dev: last_dev_q, idx: IOCE_REG_LINK, wdata: 32'h0};
          st_d = to_q ? S_END : S_LINK;
        end
      end
      S_TWO_N:
      begin
        if (!pend_q && !req_v_q)
        begin
          req_v_d = 1'b1;
          req_d = '{wr: 1'b1, dev: IOCE_DEFAULT_DEV, idx: IOCE_REG_CMD,
            wdata: 32'h0000_0001 << IOCE_CMD_TWOHOST_BIT};
          st_d = S_TWO_H;
        end
      end
      S_TWO_H:
      begin
        if (!pend_q && !req_v_q)
        begin
          req_v_d = 1'b1;
          req_d = '{wr: 1'b1, dev: own_dev, idx: IOCE_REG_CMD,
            wdata: 32'h0000_0001 << IOCE_CMD_TWOHOST_BIT};
          two_host_d = 1'b1;
          grp_walk_d = IOCE_FIRST_UNIT;
          st_d = S_GRPEN;
        end
      end
      S_END:
      begin
        req_v_d = 1'b1;
        req_d = '{wr: 1'b1, dev: last_dev_q, idx: IOCE_REG_LINK,
          wdata: (32'h1 << IOCE_LNK_CHAINEND_BIT) | (32'h1 << IOCE_LNK_TRANSMITTER_OFF_BIT_BIT)};
        grp_walk_d = IOCE_FIRST_UNIT;
        st_d = S_GRPEN;
      end
      S_GRPEN:
      begin
        if (!pend_q && !req_v_q)
        begin
          // final mask to every capable node; host bits only if allowed
          if (grp_walk_q == 5'h1f || grp_walk_q >= next_unit_q)
          begin
            st_d = S_DONE;
          end
          else
          begin
            if (want_group && cap_map_q[grp_walk_q])
            begin
              req_v_d = 1'b1;
              req_d = '{wr: 1'b1, dev: grp_walk_q, idx: IOCE_REG_GRP_EN,
                wdata: merged_q | ((forbid_q || passive_group) ? 32'h0 :
                  {28'h0, host_group_bits[3:1], 1'b0})};
            end
            grp_walk_d = grp_walk_q + 5'd1;
          end
        end
      end
      S_DONE:
      begin
        done_d = 1'b1;
        st_d = S_IDLE;
      end
      default:
      begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= S_IDLE;
      next_unit_q <= IOCE_FIRST_UNIT;
      last_dev_q <= 5'h00;
      quant_q <= 5'h00;
      grp_walk_q <= 5'h00;
      merged_q <= IOCE_MASK_RESET;
      cap_map_q <= 32'h0000_0000;
      partial_q <= 1'b0;
      forbid_q <= 1'b0;
      two_host_q <= 1'b0;
      err_end_q <= 1'b0;
      pend_q <= 1'b0;
      to_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      req_v_q <= 1'b0;
      req_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      next_unit_q <= next_unit_d;
      last_dev_q <= last_dev_d;
      quant_q <= quant_d;
      grp_walk_q <= grp_walk_d;
      merged_q <= merged_d;
      cap_map_q <= cap_map_d;
      partial_q <= partial_d;
      forbid_q <= forbid_d;
      two_host_q <= two_host_d;
      err_end_q <= err_end_d;
      pend_q <= pend_d;
      to_q <= to_d;
      rdat_q <= rdat_d;
      req_v_q <= req_v_d;
      req_q <= req_d;
      done_q <= done_d;
    end
  end

  // partitioning ends before bus master enable is permitted
  logic bm_ok_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bm_ok_q <= 1'b0;
    end
    else
    begin
      bm_ok_q <= done_d & ~start;
    end
  end

  logic busy_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= (st_d != S_IDLE);
    end
  end

  assign cfg_req_valid = req_v_q;
  assign cfg_req = req_q;
  assign done = done_q;
  assign busy = busy_q;
  assign bus_master_ok = bm_ok_q;
  assign result = '{units: next_unit_q, group_mask: merged_q, partial_grp: partial_q,
    grp_forbidden: forbid_q, two_host: two_host_q, error_end: err_end_q};
endmodule
`default_nettype wire

// ==== tb/ioce_enum_properties.sv ====
// Purpose: port properties of the chain enumeration controller
// Assumes: one configuration access outstanding at a time
// Notes: base tracking holds only while the host claims no extra units
`timescale 1ns/10ps
`default_nettype none
module ioce_enum_properties
  import ioce_pkg::*;
#(
  parameter logic [4:0] MAX_UNIT = IOCE_MAX_UNIT_DEF,
  parameter int TIMEOUT_CYC = IOCE_TIMEOUT_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chain_reset_n,
  input wire logic want_group,
  input wire logic [4:0] own_dev,
  input wire logic [3:0] host_group_bits,
  input wire logic cfg_req_valid,
  input wire ioce_req_t cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic busy,
  input wire logic done,
  input wire logic bus_master_ok,
  input wire ioce_result_t result
);
  // keeps the wait bound inside what the tools unroll cheaply
  localparam int WMAX = (TIMEOUT_CYC < 990) ? TIMEOUT_CYC + 8 : 998;
  logic [4:0] q_q, q_d, nxt_q, nxt_d;
  logic rdc_q, rdc_d, bw;
  // ****************
  // helper state
  // ****************
  assign bw = cfg_req_valid && cfg_req.wr && cfg_req.idx == IOCE_REG_CMD && cfg_req.dev == IOCE_DEFAULT_DEV
    && cfg_req.wdata[4:0] != 5'h00 && !cfg_req.wdata[IOCE_CMD_TWOHOST_BIT];
  always_comb
  begin
    rdc_d = cfg_req_valid ? (!cfg_req.wr && cfg_req.idx == IOCE_REG_CMD) : rdc_q;
    q_d = (cfg_ack && rdc_q) ? cfg_rdata[IOCE_CMD_UNITQ_LSB +: 5] : q_q;
    nxt_d = !busy ? IOCE_FIRST_UNIT : (bw ? nxt_q + q_q : nxt_q);
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q_q <= 5'h00;
      nxt_q <= IOCE_FIRST_UNIT;
      rdc_q <= 1'b0;
    end
    else
    begin
      q_q <= q_d;
      nxt_q <= nxt_d;
      rdc_q <= rdc_d;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_start_gated: assert property ($rose(busy) |-> $past(chain_reset_n))
    else $error("sizing began under chain reset");
  a_first_read: assert property ($rose(busy) |-> ##[0:1] (cfg_req_valid && !cfg_req.wr && cfg_req.dev == own_dev))
    else $error("run did not open with own read");
  a_access_wait: assert property (cfg_req_valid |=> ##[0:WMAX] (cfg_ack || cfg_req_valid || !busy))
    else $error("unanswered access never abandoned");
  a_master_after: assert property (bus_master_ok |-> done || $past(done))
    else $error("bus master enable before finish");
  a_busy_done: assert property (busy |-> !done)
    else $error("done while still sizing");
  a_base_value: assert property (bw && host_group_bits == 4'h0 |-> cfg_req.wdata[4:0] == nxt_q)
    else $error("base unit number out of sequence");
  a_unit_limit: assert property (bw |-> 6'(cfg_req.wdata[4:0]) + 6'(q_q) <= 6'(MAX_UNIT) + 6'h01)
    else $error("unit numbers past the limit");
  a_group_write: assert property (cfg_req_valid && cfg_req.wr && cfg_req.idx == IOCE_REG_GRP_EN |-> want_group)
    else $error("group enable written unasked");
  a_forbid_partial: assert property (result.grp_forbidden |-> result.partial_grp)
    else $error("forbidden without partial flag");
  c_two_host: cover property ($rose(done) && result.two_host);
  c_err_end: cover property ($rose(done) && result.error_end);
  c_forbid: cover property ($rose(done) && result.grp_forbidden);
endmodule
bind ioce_enum ioce_enum_properties #(.MAX_UNIT(MAX_UNIT), .TIMEOUT_CYC(TIMEOUT_CYC)) prop_u (
  .clk(clk), .arst_n(arst_n), .chain_reset_n(chain_reset_n), .want_group(want_group), .own_dev(own_dev),
  .host_group_bits(host_group_bits), .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .busy(busy), .done(done), .bus_master_ok(bus_master_ok), .result(result));
`default_nettype wire

// ==== tb/ioce_chain_model.sv ====
// Purpose: three chain nodes behind the host answering config accesses
// Assumes: host space at own_dev, nodes at index 1 to 3
// Notes: unmatched devices read all ones; idle read bus toggles
`timescale 1ns/10ps
`default_nettype none
module ioce_chain_model
  import ioce_pkg::*;
#(
  parameter logic [31:0] ID_WORD = 32'h5a5a_0001 // arbitrary value
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_req_valid,
  input wire ioce_req_t cfg_req,
  input wire logic [4:0] own_dev,
  input wire logic [14:0] uq,
  input wire logic [3:0] err,
  input wire logic [3:0] cap,
  input wire logic [3:0] reord,
  input wire logic [3:0] dly,
  input wire logic mute,
  input wire logic slave_end,
  input wire logic host_two,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata
);
  // nodes own no reset or power_good output at all
  ioce_req_t r;
  logic pend;
  logic [3:0] cnt, hd, tw, rdis;
  logic [4:0] base [4];
  logic [4:0] lk [4];
  logic [31:0] gen [4];
  logic [19:0] qall;
  logic [2:0] t;
  logic [31:0] rv;
  assign qall = {uq, 5'h00};
  always_comb
  begin
    t = 3'd4;
    if (r.dev == own_dev)
      t = 3'd0;
    else
      for (int i = 3; i >= 1; i--)
        if (base[i] == r.dev)
          t = 3'(i);
  end
  always_comb
  begin
    rv = 32'hffff_ffff;
    if (t != 3'd4)
      case (r.idx)
        IOCE_REG_ID: rv = ID_WORD;
        IOCE_REG_CMD: rv = {18'h0, tw[t], cap[t], slave_end && t == 3'd3, hd[t], qall[5*t +: 5], base[t]};
        IOCE_REG_LINK: rv = {22'h0, lk[t], 3'b000, err[t], t < 3'd3};
        IOCE_REG_FEATURE: rv = {31'h0, rdis[t]};
        IOCE_REG_GRP_SUP: rv = {32{cap[t]}};
        IOCE_REG_GRP_EN: rv = gen[t];
        default: rv = 32'h0;
      endcase
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r <= '0;
      pend <= 1'b0;
      cnt <= 4'h0;
      hd <= 4'h0;
      tw <= {3'b000, host_two};
      rdis <= 4'h0;
      base <= '{default: 5'h00};
      lk <= '{default: 5'h00};
      gen <= '{default: 32'h0};
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0;
    end
    else
    begin
      cfg_ack <= 1'b0;
      cfg_rdata <= ~cfg_rdata;
      if (cfg_req_valid)
      begin
        r <= cfg_req;
        cnt <= dly;
        pend <= !(mute && cfg_req.dev == 5'h00);
      end
      else if (pend && cnt != 4'h0)
        cnt <= cnt - 4'h1;
      else if (pend)
      begin
        pend <= 1'b0;
        cfg_ack <= 1'b1;
        cfg_rdata <= rv;
        if (r.wr && t != 3'd4)
          case (r.idx)
            IOCE_REG_CMD:
            begin
              hd[t] <= 1'b1;
              tw[t] <= r.wdata[IOCE_CMD_TWOHOST_BIT];
              if (t != 3'd0)
                base[t] <= r.wdata[4:0];
            end
            IOCE_REG_LINK: lk[t] <= r.wdata[9:5];
            IOCE_REG_FEATURE: rdis[t] <= r.wdata[0] & reord[t];
            IOCE_REG_GRP_EN: gen[t] <= r.wdata;
            default: ;
          endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/io_chain_enumeration_bench.sv ====
// Purpose: scenario bench for the chain enumeration controller
// Assumes: three-node chain, unit limit 4, watchdog 20 cycles
// Notes: every run resets controller and chain together
`timescale 1ns/10ps
`default_nettype none
module io_chain_enumeration_bench
  import ioce_pkg::*;
;
  logic clk, arst_n, chain_reset_n, start, is_slave, want_group;
  logic cfg_req_valid, cfg_ack, busy, done, bus_master_ok;
  logic mute, slave_end, host_two, passive_group;
  logic [31:0] cfg_rdata;
  logic [14:0] uq;
  logic [3:0] err, cap, reord, dly, host_group_bits;
  ioce_req_t cfg_req;
  ioce_result_t result;
  int bad_count, num_checks;
  ioce_enum #(.MAX_UNIT(5'h04), .TIMEOUT_CYC(20)) dut_u (
    .clk(clk), .arst_n(arst_n), .chain_reset_n(chain_reset_n), .start(start), .is_slave(is_slave),
    .want_group(want_group), .passive_group(passive_group), .own_dev(5'h1f), .host_group_bits(host_group_bits),
    .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .busy(busy), .done(done), .bus_master_ok(bus_master_ok), .result(result));
  ioce_chain_model part_u (
    .clk(clk), .arst_n(arst_n), .cfg_req_valid(cfg_req_valid), .cfg_req(cfg_req), .own_dev(5'h1f),
    .uq(uq), .err(err), .cap(cap), .reord(reord), .dly(dly), .mute(mute), .slave_end(slave_end),
    .host_two(host_two), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("ERROR %0t: got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic dflt();
    uq = {5'h01, 5'h02, 5'h01};
    err = 4'h0;
    cap = 4'h0;
    reord = 4'h0;
    dly = 4'h0;
    {mute, slave_end, host_two, is_slave, want_group, passive_group, host_group_bits} = 10'h000;
    chain_reset_n = 1'b1;
  endtask
  // a fresh reset per run, so knobs take hold in the chain too
  task automatic go();
    int n;
    n = 0;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1)
    begin
      $display("ERROR %0t: run never finished", $time);
      bad_count++;
      close_out();
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_gate();
    dflt();
    chain_reset_n = 1'b0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (10) @(negedge clk);
    chk(32'(busy), 32'h0);
    $display("test gate finished");
  endtask
  task automatic t_basic();
    dflt();
    dly = 4'h3;
    go();
    chk(32'(result.units), 32'h5);
    chk(32'({part_u.base[1], part_u.base[2], part_u.base[3]}), 32'({5'h01, 5'h02, 5'h04}));
    chk(32'(part_u.hd[3:1]), 32'h7);
    chk(32'(part_u.lk[3][1:0]), 32'h3);
    chk(32'({bus_master_ok, result.error_end, result.two_host}), 32'h4);
    $display("test basic finished");
  endtask
  task automatic t_fault();
    dflt();
    err = 4'h1;
    go();
    chk(32'({result.units, result.error_end, part_u.base[1]}), 32'({5'h01, 1'b1, 5'h00}));
    dflt();
    uq = {5'h01, 5'h04, 5'h01};
    go();
    chk(32'({result.units, part_u.base[2], part_u.lk[1][0]}), 32'({5'h02, 5'h00, 1'b1}));
    dflt();
    mute = 1'b1;
    go();
    chk(32'({result.units, part_u.base[1]}), 32'({5'h01, 5'h00}));
    $display("test fault finished");
  endtask
  task automatic t_hosts();
    dflt();
    slave_end = 1'b1;
    go();
    chk(32'({result.two_host, part_u.tw[0], part_u.tw[3], bus_master_ok}), 32'hf);
    dflt();
    is_slave = 1'b1;
    host_two = 1'b1;
    go();
    chk(32'({part_u.base[1], part_u.base[2], part_u.base[3]}), 32'h0);
    $display("test hosts finished");
  endtask
  task automatic t_group();
    dflt();
    want_group = 1'b1;
    cap = 4'he;
    go();
    chk(result.group_mask, 32'h0000_0008);
    chk(part_u.gen[2], 32'h0000_0008);
    chk(32'({result.partial_grp, result.grp_forbidden}), 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      dflt();
      want_group = 1'b1;
      cap = 4'ha;
      reord = (k == 1) ? 4'h4 : 4'h0;
      go();
      chk(32'({result.partial_grp, result.grp_forbidden}), (k == 1) ? 32'h2 : 32'h3);
    end
    // host takes two units; third node overflows the limit
    for (int k = 0; k < 2; k++)
    begin
      dflt();
      want_group = 1'b1;
      cap = 4'he;
      host_group_bits = 4'h2;
      passive_group = (k == 1);
      go();
      chk(32'({part_u.base[1], result.units}), 32'({5'h02, 5'h05}));
      chk(part_u.gen[2], (k == 1) ? 32'h0000_0010 : 32'h0000_0012);
    end
    $display("test group finished");
  endtask
  initial
  begin
    bad_count = 0;
    num_checks = 0;
    start = 1'b0;
    arst_n = 1'b0;
    dflt();
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    t_gate();
    t_basic();
    t_fault();
    t_hosts();
    t_group();
    close_out();
  end
endmodule
`default_nettype wire
